// >>> verilog/psr_pkg.sv
// Package for the pseudo-static RAM host controller.
// Assumes a 125 MHz aclk; all pin timing is counted in aclk cycles.
`default_nettype none
package psr_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // Pin geometry.
  localparam int unsigned ADDR_W        = 22;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned PAGE_WORDS    = 8;
  localparam int unsigned PAGE_BITS     = 3;
  // Timing figures as printed.
  localparam int unsigned RD_CYCLE_MIN_NS   = 70;
  localparam int unsigned CYCLE_MAX_NS      = 10000;
  localparam int unsigned PAGE_CYCLE_MIN_NS = 30;
  localparam int unsigned WR_PULSE_MIN_NS   = 50;
  localparam int unsigned WR_HIGH_MIN_NS    = 15;
  localparam int unsigned PD_PULSE_MS       = 10;
  localparam int unsigned PD_EXIT_US        = 300;
  localparam int unsigned PWR_ON_US         = 30;
  // Derived cycle counts: minimums round up, maximums round down.
  localparam int unsigned RD_CYCLE_CYC   = (RD_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYCLE_MAX_CYC  = CYCLE_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PAGE_CYC       = (PAGE_CYCLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_PULSE_CYC   = (WR_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_HIGH_CYC    = (WR_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD_PULSE_CYC   = (PD_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PD_EXIT_CYC    = (PD_EXIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWR_ON_CYC     = (PWR_ON_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register offsets.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_PAGE0  = 8'h20;
  // Command register fields.
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_BE_LSB  = 4;
  localparam logic [2:0] OP_READ  = 3'h1;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam logic [2:0] OP_PAGE  = 3'h3;
  localparam logic [2:0] OP_PDN   = 3'h4;
  localparam logic [2:0] OP_WAKE  = 3'h5;
  // Status register fields and AXI response codes.
  localparam int unsigned ST_BUSY  = 0;
  localparam int unsigned ST_READY = 1;
  localparam int unsigned ST_PDN   = 2;
  localparam int unsigned ST_VALID = 3;
  localparam int unsigned ST_ERR   = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// >>> verilog/psr_cmd_if.sv
// Command carrier between the AXI register slave and the pin sequencer.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface psr_cmd_if;
  import psr_pkg::*;
  logic              start;
  logic [2:0]        op;
  logic [1:0]        be;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              busy;
  logic              ready;
  logic              pdn;
  logic              valid;
  logic              rd_we;
  logic [2:0]        rd_idx;
  logic [DATA_W-1:0] rd_data;
  modport regs (output start, op, be, addr, wdata,
                input busy, ready, pdn, valid, rd_we, rd_idx, rd_data);
  modport seq  (input start, op, be, addr, wdata,
                output busy, ready, pdn, valid, rd_we, rd_idx, rd_data);
endinterface
`default_nettype wire

// >>> verilog/psr_axi_regs.sv
// AXI4-Lite register slave for the pseudo-static RAM host controller.
// Assumes the sequencer accepts start only while busy is low.
`default_nettype none
module psr_axi_regs
  import psr_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // Read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // Sequencer side.
  psr_cmd_if.regs          cmd
);
  logic              aw_ok_ff;
  logic              w_ok_ff;
  logic [7:0]        awa_ff;
  logic [31:0]       wd_ff;
  logic [3:0]        ws_ff;
  logic              start_ff;
  logic [2:0]        op_ff;
  logic [1:0]        be_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdat_ff;
  logic              err_ff;
  logic [DATA_W-1:0] page_ff [PAGE_WORDS];

  wire do_wr  = aw_ok_ff && w_ok_ff && !bvalid;
  wire hit_cm = (awa_ff == REG_CMD);
  wire hit_ad = (awa_ff == REG_ADDR);
  wire hit_wd = (awa_ff == REG_WDATA);
  wire map_wr = hit_cm || hit_ad || hit_wd;
  wire cm_bad = hit_cm && cmd.busy;
  wire rd_pg  = (araddr[7:5] == REG_PAGE0[7:5]);
  wire rd_map = rd_pg || araddr == REG_CMD || araddr == REG_ADDR ||
                araddr == REG_WDATA || araddr == REG_RDATA || araddr == REG_STATUS;
  wire [31:0] st_word = {27'h0, err_ff, cmd.valid, cmd.pdn, cmd.ready, cmd.busy};
  wire [31:0] rd_word =
    rd_pg                  ? {16'h0, page_ff[araddr[4:2]]} :
    araddr == REG_CMD      ? {24'h0, 2'h0, be_ff, 1'b0, op_ff} :
    araddr == REG_ADDR     ? {10'h0, addr_ff} :
    araddr == REG_WDATA    ? {16'h0, wdat_ff} :
    araddr == REG_RDATA    ? {16'h0, page_ff[0]} :
    araddr == REG_STATUS   ? st_word : 32'h0;

  assign cmd.start = start_ff;
  assign cmd.op    = op_ff;
  assign cmd.be    = be_ff;
  assign cmd.addr  = addr_ff;
  assign cmd.wdata = wdat_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff  <= 1'b0;
      awa_ff   <= 8'h00;
      wd_ff    <= 32'h0;
      ws_ff    <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      awready <= !aw_ok_ff && !awready && awvalid;
      wready  <= !w_ok_ff && !wready && wvalid;
      if (awvalid && awready) begin
        aw_ok_ff <= 1'b1;
        awa_ff   <= awaddr;
      end
      if (wvalid && wready) begin
        w_ok_ff <= 1'b1;
        wd_ff   <= wdata;
        ws_ff   <= wstrb;
      end
      if (do_wr) begin
        bvalid   <= 1'b1;
        bresp    <= (map_wr && !cm_bad) ? RESP_OKAY : RESP_SLVERR;
        aw_ok_ff <= 1'b0;
        w_ok_ff  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_ff <= 1'b0;
      op_ff    <= 3'h0;
      be_ff    <= 2'h3;
      addr_ff  <= '0;
      wdat_ff  <= '0;
      err_ff   <= 1'b0;
    end else begin
      start_ff <= do_wr && hit_cm && !cmd.busy && ws_ff[0];
      if (do_wr && hit_cm && ws_ff[0]) begin
        op_ff  <= wd_ff[CMD_OP_LSB +: 3];
        be_ff  <= wd_ff[CMD_BE_LSB +: 2];
        err_ff <= cm_bad;
      end
      if (do_wr && hit_ad) begin
        addr_ff <= wd_ff[ADDR_W-1:0];
      end
      if (do_wr && hit_wd) begin
        wdat_ff <= wd_ff[DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (cmd.rd_we) begin
      page_ff[cmd.rd_idx] <= cmd.rd_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !arready && arvalid;
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= rd_word;
        rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/psr_host.sv
// Host controller top for a 4M x 16 pseudo-static RAM on an asynchronous pin bus.
// Assumes software orders accesses over AXI4-Lite; the RAM has no clock or reset.
`default_nettype none
module psr_host
  import psr_pkg::*;
#(
  parameter int unsigned PD_PULSE = PD_PULSE_CYC,
  parameter int unsigned PD_EXIT  = PD_EXIT_CYC,
  parameter int unsigned PWR_ON   = PWR_ON_CYC
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // RAM pins.
  output var  logic [ADDR_W-1:0] word_address,
  input  wire logic [DATA_W-1:0] data_lines_i,
  output var  logic [DATA_W-1:0] data_lines_o,
  output var  logic [1:0]        data_lines_oe,
  output var  logic              primary_select_n,
  output var  logic              sleep_select,
  output var  logic              output_enable_n,
  output var  logic              write_strobe_n,
  output var  logic              low_byte_select_n,
  output var  logic              high_byte_select_n
);
  localparam int unsigned CW = 24;

  initial begin
    if (PD_PULSE < 1 || PD_EXIT < 1 || PWR_ON < 1 || PD_PULSE >= (1 << CW) ||
        PD_EXIT >= (1 << CW) || PWR_ON >= (1 << CW)) begin
      $error("psr_host: wait counts out of range");
    end
  end

  typedef enum logic [3:0] {
    S_PWRON, S_IDLE, S_RD, S_PG, S_WSET, S_WLOW, S_WEND, S_GAP, S_PDN, S_WAKE
  } psr_state_type;

  psr_cmd_if cmd ();

  psr_axi_regs u_regs (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .cmd     (cmd)
  );

  psr_state_type     st_ff;
  psr_state_type     nxt_st;
  logic [CW-1:0]     cnt_ff;
  logic [CW-1:0]     nxt_cnt;
  logic [2:0]        idx_ff;
  logic              ready_ff;
  logic              pdn_ff;
  logic              valid_ff;
  logic              rd_we_ff;
  logic [2:0]        rd_idx_ff;
  logic [DATA_W-1:0] rd_dat_ff;
  logic [DATA_W-1:0] din_s1_ff;
  logic [DATA_W-1:0] din_s2_ff;
  logic [1:0]        be_ff;

  wire is_idle  = (st_ff == S_IDLE);
  wire cnt_done = (cnt_ff == '0);
  wire go       = cmd.start && is_idle;
  wire [1:0] lane_on = ~be_ff;

  assign cmd.busy    = !is_idle;
  assign cmd.ready   = ready_ff;
  assign cmd.pdn     = pdn_ff;
  assign cmd.valid   = valid_ff;
  assign cmd.rd_we   = rd_we_ff;
  assign cmd.rd_idx  = rd_idx_ff;
  assign cmd.rd_data = rd_dat_ff;

  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 1'b1;
    unique case (st_ff)
      S_PWRON: if (cnt_done) nxt_st = S_IDLE;
      S_IDLE: begin
        if (cmd.start && ready_ff) begin
          unique case (cmd.op)
            OP_READ: begin
              nxt_st  = S_RD;
              nxt_cnt = CW'(RD_CYCLE_CYC);
            end
            OP_PAGE: begin
              nxt_st  = S_PG;
              nxt_cnt = CW'(RD_CYCLE_CYC);
            end
            OP_WRITE: begin
              nxt_st  = S_WSET;
              nxt_cnt = '0;
            end
            OP_PDN: begin
              nxt_st  = S_PDN;
              nxt_cnt = CW'(PD_PULSE);
            end
            default: nxt_st = S_IDLE;
          endcase
        end else if (cmd.start && pdn_ff && cmd.op == OP_WAKE) begin
          nxt_st  = S_WAKE;
          nxt_cnt = CW'(PD_EXIT);
        end
      end
      S_RD: if (cnt_done) nxt_st = S_GAP;
      S_PG: begin
        if (cnt_done) begin
          nxt_cnt = CW'(PAGE_CYC);
          if (idx_ff == 3'(PAGE_WORDS - 1)) begin
            nxt_st  = S_GAP;
            nxt_cnt = CW'(WR_HIGH_CYC);
          end
        end
      end
      S_WSET: begin
        nxt_st  = S_WLOW;
        nxt_cnt = CW'(WR_PULSE_CYC);
      end
      S_WLOW: begin
        if (cnt_done) begin
          nxt_st  = S_WEND;
          nxt_cnt = CW'(RD_CYCLE_CYC - WR_PULSE_CYC);
        end
      end
      S_WEND: begin
        if (cnt_done) begin
          nxt_st  = S_GAP;
          nxt_cnt = CW'(WR_HIGH_CYC);
        end
      end
      S_GAP: if (cnt_done) nxt_st = S_IDLE;
      S_PDN: if (cnt_done) nxt_st = S_IDLE;
      S_WAKE: if (cnt_done) nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff  <= S_PWRON;
      cnt_ff <= CW'(PWR_ON);
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= (st_ff == S_RD && cnt_done) ? CW'(WR_HIGH_CYC) : nxt_cnt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      din_s1_ff <= '0;
      din_s2_ff <= '0;
    end else begin
      din_s1_ff <= data_lines_i;
      din_s2_ff <= din_s1_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_ff <= 3'h0;
    end else if (go) begin
      idx_ff <= 3'h0;
    end else if (st_ff == S_PG && cnt_done) begin
      idx_ff <= idx_ff + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_we_ff  <= 1'b0;
      rd_idx_ff <= 3'h0;
      rd_dat_ff <= '0;
    end else begin
      rd_we_ff  <= (st_ff == S_RD || st_ff == S_PG) && cnt_done;
      rd_idx_ff <= (st_ff == S_PG) ? idx_ff : 3'h0;
      rd_dat_ff <= din_s2_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_ff <= 1'b0;
      pdn_ff   <= 1'b0;
      valid_ff <= 1'b1;
      be_ff    <= 2'h3;
    end else begin
      if (st_ff == S_PWRON && cnt_done) ready_ff <= 1'b1;
      if (go && cmd.op == OP_PDN && ready_ff) begin
        ready_ff <= 1'b0;
        pdn_ff   <= 1'b1;
        valid_ff <= 1'b0;
      end
      if (st_ff == S_WAKE && cnt_done) begin
        ready_ff <= 1'b1;
        pdn_ff   <= 1'b0;
      end
      if (go && cmd.op == OP_WRITE && ready_ff) valid_ff <= 1'b1;
      if (go) be_ff <= cmd.be;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_address       <= '0;
      data_lines_o       <= '0;
      data_lines_oe      <= 2'h0;
      primary_select_n   <= 1'b1;
      sleep_select       <= 1'b1;
      output_enable_n    <= 1'b1;
      write_strobe_n     <= 1'b1;
      low_byte_select_n  <= 1'b1;
      high_byte_select_n <= 1'b1;
    end else begin
      if (go) word_address <= cmd.addr;
      if (nxt_st == S_PG) begin
        word_address[PAGE_BITS-1:0] <= (st_ff == S_PG && cnt_done) ? idx_ff + 3'h1 : idx_ff;
      end
      if (go && cmd.op == OP_PAGE) word_address[PAGE_BITS-1:0] <= 3'h0;
      if (go) data_lines_o <= cmd.wdata;
      primary_select_n <= !(nxt_st == S_RD || nxt_st == S_PG || nxt_st == S_WSET ||
                            nxt_st == S_WLOW || nxt_st == S_WEND);
      output_enable_n  <= !(nxt_st == S_RD || nxt_st == S_PG);
      write_strobe_n   <= !(nxt_st == S_WLOW);
      low_byte_select_n  <= !(lane_sel(nxt_st) && (go ? !cmd.be[0] : lane_on[0]));
      high_byte_select_n <= !(lane_sel(nxt_st) && (go ? !cmd.be[1] : lane_on[1]));
      data_lines_oe <= (nxt_st == S_WSET || nxt_st == S_WLOW || nxt_st == S_WEND) ?
                       (go ? ~cmd.be : lane_on) : 2'h0;
      sleep_select  <= !(nxt_st == S_PDN);
    end
  end

  function automatic logic lane_sel(input psr_state_type s);
    lane_sel = (s == S_RD || s == S_PG || s == S_WSET || s == S_WLOW || s == S_WEND);
  endfunction
endmodule
`default_nettype wire

// >>> tb/psr_ram_model.sv
// Behavioural 4M x 16 pseudo-static RAM on the far side of the host pins.
// Assumes the host keeps the pin timing; contents are lost in power-down.
`default_nettype none
module psr_ram_model
  import psr_pkg::*;
#(
  parameter int unsigned ACC_NS = 20
) (
  // Host pins.
  input  wire logic [ADDR_W-1:0] word_address,
  input  wire logic [DATA_W-1:0] data_lines_o,
  input  wire logic [1:0]        data_lines_oe,
  input  wire logic              primary_select_n,
  input  wire logic              sleep_select,
  input  wire logic              output_enable_n,
  input  wire logic              write_strobe_n,
  input  wire logic              low_byte_select_n,
  input  wire logic              high_byte_select_n,
  // Data back to the host.
  output var  logic [DATA_W-1:0] data_lines_i
);
  timeunit 1ns;
  timeprecision 1ps;
  bit   [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire  logic        sel = !primary_select_n && sleep_select;
  wire  logic        rd  = sel && !output_enable_n && write_strobe_n;
  wire  logic [15:0] cur = mem[word_address];
  // selected lanes only.
  // Lanes left floating show the inverse word so a stale value never passes.
  assign #(ACC_NS) data_lines_i = {(rd && !high_byte_select_n) ? cur[15:8] : ~cur[15:8],
                                   (rd && !low_byte_select_n) ? cur[7:0] : ~cur[7:0]};
  always @(posedge write_strobe_n) begin
    if (sel && !low_byte_select_n)
      mem[word_address][7:0] = data_lines_oe[0] ? data_lines_o[7:0] : ~cur[7:0];
    if (sel && !high_byte_select_n)
      mem[word_address][15:8] = data_lines_oe[1] ? data_lines_o[15:8] : ~cur[15:8];
  end
  // refresh and page reads need no extra logic.
  always @(negedge sleep_select) begin
    foreach (mem[i]) mem[i] = ~i[15:0];
  end
endmodule
`default_nettype wire

// >>> tb/psr_host_asserts.sv
// Concurrent checks on the RAM pins of the host controller.
// Assumes it is bound into psr_host; all counts are in aclk cycles.
`default_nettype none
module psr_host_asserts
  import psr_pkg::*;
#(
  parameter int unsigned PD_PULSE = PD_PULSE_CYC,
  parameter int unsigned PD_EXIT  = PD_EXIT_CYC,
  parameter int unsigned PWR_ON   = PWR_ON_CYC
) (
  // Clock and reset.
  input wire logic              aclk,
  input wire logic              aresetn,
  // RAM pins.
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic [1:0]        data_lines_oe,
  input wire logic              primary_select_n,
  input wire logic              sleep_select,
  input wire logic              output_enable_n,
  input wire logic              write_strobe_n,
  input wire logic              low_byte_select_n,
  input wire logic              high_byte_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] low_cnt_ff;
  logic [31:0] quiet_cnt_ff;
  logic [31:0] quiet_min_ff;
  logic [31:0] sel_cnt_ff;
  wire  logic [2:0] sels = {primary_select_n, low_byte_select_n, high_byte_select_n};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt_ff   <= '0;
      quiet_cnt_ff <= '0;
      quiet_min_ff <= PWR_ON;
      sel_cnt_ff   <= '0;
    end else begin
      low_cnt_ff   <= sleep_select ? '0 : low_cnt_ff + 1;
      quiet_cnt_ff <= $rose(sleep_select) ? '0 : quiet_cnt_ff + 1;
      quiet_min_ff <= $rose(sleep_select) ? PD_EXIT : quiet_min_ff;
      sel_cnt_ff   <= primary_select_n ? '0 : sel_cnt_ff + 1;
    end
  end
  sequence s_wr_low;
    !write_strobe_n [*7];
  endsequence
  sequence s_rd_hold;
    (!output_enable_n && $stable(word_address[ADDR_W-1:PAGE_BITS])) [*8];
  endsequence
  a_wr_pulse: assert property ($fell(write_strobe_n) |-> s_wr_low)
    else $error("write pulse too short");
  a_wr_gap: assert property ($rose(write_strobe_n) |-> write_strobe_n [*2])
    else $error("write strobe high too short");
  a_sel_setup: assert property ($fell(write_strobe_n) |-> $stable(sels) && !sels[2])
    else $error("selects moved at strobe fall");
  a_sel_hold: assert property ($rose(write_strobe_n)
    |-> ($stable(sels) && !sels[2]) [*2])
    else $error("selects released early");
  a_oe_in_write: assert property (!write_strobe_n
    |-> output_enable_n && data_lines_oe != 0)
    else $error("output enable low in write");
  a_no_fight: assert property (!output_enable_n |-> data_lines_oe == 2'b00)
    else $error("bus driven during read");
  // The select counter holds the number of low cycles when the select rises.
  a_sel_cycle: assert property ($rose(primary_select_n)
    |-> sel_cnt_ff >= RD_CYCLE_CYC)
    else $error("access cycle too short");
  a_rd_hold: assert property ($fell(output_enable_n) |=> s_rd_hold)
    else $error("read ended or page moved");
  a_page_step: assert property (!output_enable_n && $changed(word_address[PAGE_BITS-1:0])
    |=> ($stable(word_address[PAGE_BITS-1:0]) || output_enable_n) [*3])
    else $error("in-page step too fast");
  a_pd_quiet: assert property (!sleep_select |-> primary_select_n)
    else $error("select low in power-down");
  a_pd_pulse: assert property ($rose(sleep_select) |-> low_cnt_ff >= PD_PULSE)
    else $error("power-down pulse too short");
  a_wake_quiet: assert property ($fell(primary_select_n)
    |-> quiet_cnt_ff >= quiet_min_ff)
    else $error("access too soon after wake");
  a_cycle_max: assert property (sel_cnt_ff < CYCLE_MAX_CYC)
    else $error("access cycle too long");
endmodule
bind psr_host psr_host_asserts #(.PD_PULSE(PD_PULSE), .PD_EXIT(PD_EXIT), .PWR_ON(PWR_ON))
  chk_u (.aclk(aclk), .aresetn(aresetn), .word_address(word_address),
         .data_lines_oe(data_lines_oe), .primary_select_n(primary_select_n),
         .sleep_select(sleep_select), .output_enable_n(output_enable_n),
         .write_strobe_n(write_strobe_n), .low_byte_select_n(low_byte_select_n),
         .high_byte_select_n(high_byte_select_n));
`default_nettype wire

// >>> tb/psr_host_tb.sv
// Self-checking bench for the pseudo-static RAM host controller.
// Assumes the RAM model on the pins and AXI4-Lite access to the registers.
`default_nettype none
module psr_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psr_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [7:0]        awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'hf;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       rdata;
  logic [1:0]        bresp, rresp, data_lines_oe;
  logic [ADDR_W-1:0] word_address;
  logic [DATA_W-1:0] data_lines_i, data_lines_o;
  logic              primary_select_n, sleep_select, output_enable_n, write_strobe_n;
  logic              low_byte_select_n, high_byte_select_n;
  int                error_cnt = 0, n_compared = 0;
  always #4 aclk = ~aclk;
  psr_host #(.PD_PULSE(20), .PD_EXIT(20), .PWR_ON(10)) dut_u (.aclk, .aresetn, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .word_address, .data_lines_i,
    .data_lines_o, .data_lines_oe, .primary_select_n, .sleep_select, .output_enable_n,
    .write_strobe_n, .low_byte_select_n, .high_byte_select_n);
  psr_ram_model ram_u (.word_address, .data_lines_o, .data_lines_oe, .primary_select_n,
    .sleep_select, .output_enable_n, .write_strobe_n, .low_byte_select_n,
    .high_byte_select_n, .data_lines_i);
  task automatic stop_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, mask);
    n_compared++;
    if ((got & mask) !== (exp & mask)) begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 100) begin
      error_cnt++;
      $display("BAD %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    tmo(n);
    chk({30'h0, bresp}, {30'h0, er}, 32'h3);
    bready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    tmo(n);
    chk(rdata, e, m);
    chk({30'h0, rresp}, {30'h0, er}, 32'h3);
    rready <= 1'b0;
  endtask
  // Polls STATUS until bit b reads v; each poll is itself checked for OKAY.
  task automatic idle(input int b, input logic v);
    int n;
    for (n = 0; n < 100; n++) begin
      rdc(REG_STATUS, 32'h0, 32'h0, RESP_OKAY);
      if (rdata[b] === v) break;
    end
    tmo(n);
  endtask
  task automatic op(input logic [2:0] o, input logic [1:0] bd, input logic [21:0] a,
                    input logic [15:0] d);
    wr(REG_ADDR, {10'h0, a}, RESP_OKAY);
    wr(REG_WDATA, {16'h0, d}, RESP_OKAY);
    wr(REG_CMD, {26'h0, bd, 1'b0, o}, RESP_OKAY);
    idle(ST_BUSY, 1'b0);
  endtask
  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic t_start;
    rdc(REG_STATUS, 32'h9, 32'h1f, RESP_OKAY);
    idle(ST_READY, 1'b1);
    rdc(8'h40, 32'h0, 32'hffffffff, RESP_SLVERR);
    wr(8'h44, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_lanes;
    logic [15:0] e;
    for (int b = 0; b < 3; b++) begin
      e = {b == 2 ? 8'h12 : 8'hab, b == 1 ? 8'h34 : 8'hcd};
      op(OP_WRITE, 2'b00, 22'h3fffff, 16'h1234);
      op(OP_WRITE, b[1:0], 22'h3fffff, 16'habcd);
      op(OP_READ, 2'b00, 22'h3fffff, 16'h0);
      rdc(REG_RDATA, {16'h0, e}, 32'hffff, RESP_OKAY);
      op(OP_READ, b[1:0], 22'h3fffff, 16'h0);
      rdc(REG_RDATA, {16'h0, e}, {16'h0, b == 2 ? 8'h0 : 8'hff, b == 1 ? 8'h0 : 8'hff},
          RESP_OKAY);
    end
  endtask
  task automatic t_page;
    for (int i = 0; i < 8; i++) op(OP_WRITE, 2'b00, 22'h2a5ff8 + i, 16'h5a00 + i);
    op(OP_PAGE, 2'b00, 22'h2a5ff8, 16'h0);
    for (int i = 0; i < 8; i++) begin
      rdc(REG_PAGE0 + 8'(4 * i), 32'h5a00 + i, 32'hffff, RESP_OKAY);
    end
  endtask
  task automatic t_busy;
    wr(REG_ADDR, 32'h0, RESP_OKAY);
    wr(REG_CMD, {29'h0, OP_READ}, RESP_OKAY);
    wr(REG_CMD, {29'h0, OP_READ}, RESP_SLVERR);
    rdc(REG_STATUS, 32'h10, 32'h10, RESP_OKAY);
    idle(ST_BUSY, 1'b0);
    wr(REG_CMD, {29'h0, OP_WAKE}, RESP_OKAY);
    rdc(REG_STATUS, 32'h2, 32'h7, RESP_OKAY);
  endtask
  task automatic t_pdn;
    wr(REG_CMD, {29'h0, OP_PDN}, RESP_OKAY);
    idle(ST_PDN, 1'b1);
    idle(ST_BUSY, 1'b0);
    rdc(REG_STATUS, 32'h4, 32'hc, RESP_OKAY);
    wr(REG_CMD, {29'h0, OP_READ}, RESP_OKAY);
    rdc(REG_STATUS, 32'h0, 32'h1, RESP_OKAY);
    wr(REG_CMD, {29'h0, OP_WAKE}, RESP_OKAY);
    idle(ST_READY, 1'b1);
    rdc(REG_STATUS, 32'h0, 32'hc, RESP_OKAY);
    op(OP_WRITE, 2'b00, 22'h000001, 16'h00c3);
    op(OP_READ, 2'b00, 22'h000001, 16'h0);
    rdc(REG_RDATA, 32'hc3, 32'hffff, RESP_OKAY);
    rdc(REG_STATUS, 32'h8, 32'h8, RESP_OKAY);
  endtask
  initial begin
    do_reset();
    t_start();
    t_lanes();
    t_page();
    t_busy();
    t_pdn();
    do_reset();
    t_start();
    stop_test();
  end
endmodule
`default_nettype wire
